// ==== dv/boundary_scan_tap_usage_test.sv ====
// Purpose: Self-checking bench with tester and device facing each other
// Assumes: Tester makes the scan clock; bench drives commands and pins
// Notes:   Expected words come from the capture, bypass and cell rules
`timescale 1ns/1ps
module boundary_scan_tap_usage_test;
  import bstap_pkg::*;
  logic        clock_in, rst_n_in, cmd_valid, cmd_ready, cmd_is_ir, rsp_valid;
  logic [5:0]  cmd_len;
  logic [31:0] cmd_data, rsp_data, got;
  logic [3:0]  pin_in, core_out, core_oe_n, out_only, pin_out, pin_oe_n, tap_state;
  logic        keep_buf, in_system_programming_session, extest, full_seen;
  int          err_count, checks, acc, n;

  bstap_if link_if ();
  bstap_tester u_bstap_tester (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(link_if),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_is_ir_in(cmd_is_ir),
    .cmd_len_in(cmd_len), .cmd_data_in(cmd_data), .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp_data));
  bstap_device u_bstap_device (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(link_if),
    .pin_in(pin_in), .core_out_in(core_out), .core_oe_n_in(core_oe_n),
    .output_only_in(out_only), .keep_input_buffers_in(keep_buf),
    .in_system_programming_session_in(in_system_programming_session), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n),
    .extest_active_out(extest), .tap_state_out(tap_state));
  bstap_link_asserts u_bstap_link_asserts (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .tck(link_if.tck), .tms(link_if.tms), .tdi(link_if.tdi), .tdo(link_if.tdo));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Response is a one-cycle pulse, so it is looked for every cycle
  task automatic wait_rsp();
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (rsp_valid !== 1'b1 && n < 3000);
    if (n >= 3000) chk("response timeout", 32'h0, 32'h1);
    got = rsp_data;
    // Device steps three cycles after the tester's edge; let it settle
    repeat (4) @(posedge clock_in);
  endtask

  task automatic run(input logic ir, input logic [5:0] len, input logic [31:0] d);
    cmd_valid <= 1'b1;
    cmd_is_ir <= ir;
    cmd_len   <= len;
    cmd_data  <= d;
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (cmd_ready !== 1'b1 && n < 3000);
    if (n >= 3000) chk("command accept timeout", 32'h0, 32'h1);
    @(posedge clock_in);
    cmd_valid <= 1'b0;
    wait_rsp();
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Clock, watchdog and tests
  // --------------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // Whole sequence needs a few thousand cycles; this leaves ample slack
  initial begin
    repeat (30000) @(posedge clock_in);
    err_count++;
    test_done();
  end

  initial begin
    rst_n_in = 1'b0;
    cmd_valid = 1'b0;
    cmd_is_ir = 1'b0;
    cmd_len = 6'h00;
    cmd_data = 32'h0;
    pin_in = 4'h9;
    core_out = 4'h5;
    core_oe_n = 4'hc;
    out_only = 4'h1;
    keep_buf = 1'b0;
    in_system_programming_session = 1'b0;
    err_count = 0;
    checks = 0;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(negedge clock_in);
    chk("tap state", 32'(BSTAP_RESET), 32'(tap_state));
    chk("extest flag", 32'h0, 32'(extest));
    chk("pins follow core", 32'(core_out), 32'(pin_out));
    chk("mode high at release", 32'h1, 32'(link_if.tms));
    chk("clock low at release", 32'h0, 32'(link_if.tck));
    @(posedge clock_in);
    $display("test reset done");
    run(1'b1, 6'h0a, 32'(BSTAP_IR_BYPASS));
    chk("ir capture", 32'(BSTAP_IR_CAPTURE), 32'(got[9:0]));
    chk("tap state idle", 32'(BSTAP_IDLE), 32'(tap_state));
    run(1'b0, 6'h08, 32'h0000_00b5);
    chk("bypass path", 32'h6a, 32'(got[7:0]));
    $display("test bypass done");
    run(1'b1, 6'h0a, 32'(BSTAP_IR_SAMPLE));
    run(1'b0, 6'h08, 32'h0000_003a);
    chk("output-only capture off", 32'h8, 32'(got[3:0]));
    keep_buf <= 1'b1;
    run(1'b0, 6'h08, 32'h0000_003a);
    chk("output-only capture kept", 32'h9, 32'(got[3:0]));
    run(1'b1, 6'h0a, 32'(BSTAP_IR_EXTEST));
    chk("extest flag on", 32'h1, 32'(extest));
    chk("enable cells", 32'h3, 32'(pin_oe_n));
    chk("value cells", 32'h2, 32'(pin_out[3:2]));
    $display("test extest done");
    run(1'b1, 6'h0a, 32'(BSTAP_IR_BYPASS));
    chk("core back on pins", 32'(core_out), 32'(pin_out));
    chk("core enables back", 32'(core_oe_n), 32'(pin_oe_n));
    in_system_programming_session <= 1'b1;
    run(1'b1, 6'h0a, 32'(BSTAP_IR_EXTEST));
    chk("extest refused in session", 32'h0, 32'(extest));
    in_system_programming_session <= 1'b0;
    $display("test session done");
    // Hold valid through the refusal so the full FIFO is really pushed on
    cmd_valid <= 1'b1;
    cmd_is_ir <= 1'b1;
    cmd_len <= 6'h0a;
    cmd_data <= 32'(BSTAP_IR_BYPASS);
    acc = 0;
    full_seen = 1'b0;
    repeat (12) begin
      @(negedge clock_in);
      if (cmd_ready === 1'b1) acc++;
      else full_seen = 1'b1;
      @(posedge clock_in);
    end
    cmd_valid <= 1'b0;
    chk("fifo refused", 32'h1, 32'(full_seen));
    chk("fifo depth", 32'h1, 32'(acc >= BSTAP_FIFO_DEPTH));
    repeat (acc) begin
      wait_rsp();
      chk("queued capture", 32'(BSTAP_IR_CAPTURE), 32'(got[9:0]));
    end
    $display("test fifo done");
    test_done();
  end
endmodule

// ==== dv/bstap_link_asserts.sv ====
// Purpose: Protocol checks on the four-wire scan link between the two ends
// Assumes: Scan clock is made by the tester as eight clock_in periods
// Notes:   Sees only the link wires; core pins are judged by the bench
`timescale 1ns/1ps
module bstap_link_asserts
  import bstap_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  input  wire logic tdo
);
  default clocking link_cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // --------------------------------------------------------------------
  // Controller tracker
  // --------------------------------------------------------------------
  // The exit walk shows the same mode levels as an instruction walk, so
  // the pattern checks are anchored on a tracked idle state
  logic         tck_d;
  bstap_state_t walk_st;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      tck_d   <= 1'b0;
      walk_st <= BSTAP_RESET;
    end else begin
      tck_d <= tck;
      if (tck && !tck_d) begin
        walk_st <= bstap_next(walk_st, tms);
      end
    end
  end

  // --------------------------------------------------------------------
  // Sequences
  // --------------------------------------------------------------------
  sequence s_rise_mode(m);
    $rose(tck) && (tms == m);
  endsequence

  // Walk from idle into instruction shift, plus a first shift rise
  sequence s_ir_walk;
    s_rise_mode(1'b1) ##8 s_rise_mode(1'b1) ##8 s_rise_mode(1'b0) ##8 s_rise_mode(1'b0)
      ##8 s_rise_mode(1'b0);
  endsequence

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_idle_ties_reset: assert property ($rose(rst_n_in) |-> tms && tdi && !tck)
    else $error("link not idle after reset");
  a_tdo_reset_low: assert property ($rose(rst_n_in) |-> !tdo)
    else $error("data out not low after reset");
  a_tck_high_span: assert property ($rose(tck) |-> tck [*4] ##1 !tck)
    else $error("scan clock high phase wrong");
  a_tck_low_span: assert property ($fell(tck) |-> (!tck) [*4])
    else $error("scan clock low phase too short");
  a_link_held_high: assert property (tck && $past(tck) |-> $stable(tms) && $stable(tdi))
    else $error("mode or data in moved while clock high");
  a_tdo_at_low: assert property ($changed(tdo) |-> !tck)
    else $error("data out moved while clock high");
  a_tdo_hold_rise: assert property ($rose(tck) |-> ##1 $stable(tdo) [*3])
    else $error("data out moved after rising edge");
  a_ir_first_bit: assert property ((walk_st == BSTAP_IDLE) ##0 s_ir_walk |-> ##3 tdo)
    else $error("capture pattern bit 0 missing");
  a_ir_pattern_bits: assert property ((walk_st == BSTAP_IDLE) ##0 s_ir_walk
    |-> ##11 !tdo ##8 tdo)
    else $error("capture pattern bits 1 and 2 wrong");
endmodule

// ==== hdl/bstap_device.sv ====
// Purpose: Device end of the scan link: controller, instruction and data paths
// Assumes: Scan clock is sampled by clock_in through three flip-flops
// Notes:   Shift outputs change on the sampled falling scan-clock edge
`timescale 1ns/1ps
module bstap_device
  import bstap_pkg::*;
#(
  parameter int PINS = BSTAP_PINS
) (
  input  wire logic            clock_in,
  input  wire logic            rst_n_in,
  bstap_if.device              link,
  input  wire logic [PINS-1:0] pin_in,
  input  wire logic [PINS-1:0] core_out_in,
  input  wire logic [PINS-1:0] core_oe_n_in,
  input  wire logic [PINS-1:0] output_only_in,
  input  wire logic            keep_input_buffers_in,
  input  wire logic            in_system_programming_session_in,
  output logic      [PINS-1:0] pin_out,
  output logic      [PINS-1:0] pin_oe_n_out,
  output logic                 extest_active_out,
  output logic      [3:0]      tap_state_out
);
  localparam int BW = 2 * PINS;

  typedef struct packed {
    logic [2:0]           tck_sync;
    logic [1:0]           tms_sync;
    logic [1:0]           tdi_sync;
    bstap_state_t         state;
    logic [BSTAP_IR_W-1:0] ir_shift;
    logic [BSTAP_IR_W-1:0] ir;
    logic                 bypass;
    logic [BW-1:0]        bsr;
    logic [PINS-1:0]      output_value_update_cell;
    logic [PINS-1:0]      output_enable_update_cell;
    logic                 tdo;
  } bstap_dev_t;

  bstap_dev_t st;
  bstap_dev_t next_st;
  logic       tck_rise;
  logic       tck_fall;
  logic       sel_bsr;
  logic       is_extest;
  logic [PINS-1:0] cap_pins;

  // Edges read only the second and third stages, never the first
  assign tck_rise  = st.tck_sync[1] && !st.tck_sync[2];
  assign tck_fall  = !st.tck_sync[1] && st.tck_sync[2];
  // Boundary tests are refused during a programming session
  assign is_extest = (st.ir == BSTAP_IR_EXTEST) && !in_system_programming_session_in;
  assign sel_bsr   = ((st.ir == BSTAP_IR_EXTEST) || (st.ir == BSTAP_IR_SAMPLE))
                     && !in_system_programming_session_in;
  // Output-only pins read low unless their input buffers are kept on
  assign cap_pins  = pin_in & ~(output_only_in & {PINS{!keep_input_buffers_in}});

  assign link.tdo          = st.tdo;
  assign extest_active_out = is_extest;
  assign tap_state_out     = st.state;

  // -----------------------------------------------------------------------
  // Pin multiplexers
  // -----------------------------------------------------------------------
  always_comb begin
    if (is_extest) begin
      pin_out      = st.output_value_update_cell;
      pin_oe_n_out = st.output_enable_update_cell;
    end else begin
      pin_out      = core_out_in;
      pin_oe_n_out = core_oe_n_in;
    end
  end

  // -----------------------------------------------------------------------
  // Controller and shift paths
  // -----------------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.tck_sync = {st.tck_sync[1:0], link.tck};
    next_st.tms_sync = {st.tms_sync[0], link.tms};
    next_st.tdi_sync = {st.tdi_sync[0], link.tdi};
    if (tck_rise) begin
      next_st.state = bstap_next(st.state, st.tms_sync[1]);
      case (st.state)
        BSTAP_RESET: begin
          next_st.ir = BSTAP_IR_RESET;
        end
        BSTAP_CAP_IR: begin
          next_st.ir_shift = BSTAP_IR_CAPTURE;
        end
        BSTAP_SH_IR: begin
          next_st.ir_shift = {st.tdi_sync[1], st.ir_shift[BSTAP_IR_W-1:1]};
        end
        BSTAP_UPD_IR: begin
          next_st.ir = st.ir_shift;
        end
        BSTAP_CAP_DR: begin
          next_st.bypass = 1'b0;
          next_st.bsr    = {core_oe_n_in, cap_pins};
        end
        BSTAP_SH_DR: begin
          if (sel_bsr) begin
            next_st.bsr = {st.tdi_sync[1], st.bsr[BW-1:1]};
          end else begin
            next_st.bypass = st.tdi_sync[1];
          end
        end
        BSTAP_UPD_DR: begin
          if (sel_bsr) begin
            next_st.output_value_update_cell  = st.bsr[PINS-1:0];
            next_st.output_enable_update_cell = st.bsr[BW-1:PINS];
          end
        end
        default: begin
        end
      endcase
    end
    if (tck_fall) begin
      // Data out follows the shift register head on the falling edge
      case (st.state)
        BSTAP_SH_IR: next_st.tdo = st.ir_shift[0];
        BSTAP_SH_DR: next_st.tdo = sel_bsr ? st.bsr[0] : st.bypass;
        default:     next_st.tdo = st.tdo;
      endcase
    end
  end

  // Reset state is the controller's BSTAP_RESET state, not idle; no enable gates it
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      st                           <= '0;
      st.state                     <= BSTAP_RESET;
      st.ir                        <= BSTAP_IR_RESET;
      st.output_enable_update_cell <= {PINS{1'b1}};
    end else begin
      st <= next_st;
    end
  end
endmodule

// ==== hdl/bstap_fifo.sv ====
// Purpose: Small flip-flop FIFO with valid and ready on both sides
// Assumes: One clock, synchronous active-low reset
// Notes:   Depth must be a power of two
`timescale 1ns/1ps
module bstap_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } bstap_fifo_t;

  bstap_fifo_t st;
  bstap_fifo_t next_st;
  logic        full;
  logic        empty;

  assign full          = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
  assign empty         = (st.wr == st.rd);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = st.mem[st.rd[AW-1:0]];

  always_comb begin
    next_st = st;
    if (in_valid_in && !full) begin
      next_st.mem[st.wr[AW-1:0]] = in_data_in;
      next_st.wr                 = st.wr + 1'b1;
    end
    if (out_ready_in && !empty) begin
      next_st.rd = st.rd + 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ==== hdl/bstap_tester.sv ====
// Purpose: Tester end: walks the controller and shifts instruction or data words
// Assumes: Scan clock made here by dividing clock_in
// Notes:   Commands pass through an eight-word FIFO
`timescale 1ns/1ps
module bstap_tester
  import bstap_pkg::*;
#(
  parameter int LEN_W = 6
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  bstap_if.tester               link,
  input  wire logic             cmd_valid_in,
  output logic                  cmd_ready_out,
  input  wire logic             cmd_is_ir_in,
  input  wire logic [LEN_W-1:0] cmd_len_in,
  input  wire logic [31:0]      cmd_data_in,
  output logic                  rsp_valid_out,
  output logic      [31:0]      rsp_data_out
);
  localparam int CW = 1 + LEN_W + 32;

  typedef enum logic [2:0] {T_RESET, T_IDLE, T_WALK, T_SHIFT, T_EXIT} bstap_tst_state_t;

  typedef struct packed {
    bstap_tst_state_t ph;
    logic [7:0]       div;
    logic             tck;
    logic [4:0]       seq;
    logic [2:0]       nseq;
    logic [LEN_W-1:0] cnt;
    logic [LEN_W-1:0] len;
    logic [31:0]      sh;
    logic [31:0]      cap;
    logic             tms;
    logic             tdi;
    logic [1:0]       tdo_sync;
    logic             rsp_valid;
    logic [31:0]      rsp;
  } bstap_tst_t;

  bstap_tst_t    st;
  bstap_tst_t    next_st;
  logic          f_valid;
  logic          f_ready;
  logic [CW-1:0] f_data;
  logic          rise;

  bstap_fifo #(.WIDTH(CW), .DEPTH(BSTAP_FIFO_DEPTH)) u_fifo (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (cmd_valid_in),
    .in_ready_out  (cmd_ready_out),
    .in_data_in    ({cmd_is_ir_in, cmd_len_in, cmd_data_in}),
    .out_valid_out (f_valid),
    .out_ready_in  (f_ready),
    .out_data_out  (f_data)
  );

  assign link.tck      = st.tck;
  assign link.tms      = st.tms;
  assign link.tdi      = st.tdi;
  assign rsp_valid_out = st.rsp_valid;
  assign rsp_data_out  = st.rsp;
  assign rise          = (st.div == BSTAP_HALF_CNT - 8'h01) && !st.tck;
  assign f_ready       = rise && (st.ph == T_IDLE);

  // -----------------------------------------------------------------------
  // Divider and sequencer; mode and data move with the clock's rise, which
  // is safe only because the far end sees all three after the same two stages
  // -----------------------------------------------------------------------
  always_comb begin
    next_st           = st;
    next_st.rsp_valid = 1'b0;
    next_st.tdo_sync  = {st.tdo_sync[0], link.tdo};
    next_st.div       = st.div + 8'h01;
    if (st.div == BSTAP_HALF_CNT - 8'h01) begin
      next_st.div = 8'h00;
      next_st.tck = !st.tck;
    end
    if (rise) begin
      case (st.ph)
        T_RESET: begin
          next_st.tms = 1'b0;
          next_st.ph  = T_IDLE;
        end
        T_IDLE: begin
          next_st.tms = 1'b0;
          if (f_valid) begin
            // From idle: 1,1,0,0 to instruction shift, 1,0,0 to data shift
            next_st.seq  = f_data[CW-1] ? 5'h03 : 5'h01;
            next_st.nseq = f_data[CW-1] ? 3'h4 : 3'h3;
            next_st.len  = f_data[32 +: LEN_W];
            next_st.cnt  = f_data[32 +: LEN_W];
            next_st.sh   = f_data[31:0];
            next_st.cap  = 32'h0000_0000;
            next_st.tms  = f_data[CW-1] ? 1'b1 : 1'b1;
            next_st.ph   = T_WALK;
          end
        end
        T_WALK: begin
          next_st.nseq = st.nseq - 3'h1;
          next_st.seq  = {1'b0, st.seq[4:1]};
          next_st.tms  = st.seq[1];
          if (st.nseq == 3'h1) begin
            next_st.tdi = st.sh[0];
            next_st.tms = (st.len == LEN_W'(1));
            next_st.ph  = T_SHIFT;
          end
        end
        T_SHIFT: begin
          // Data out sampled on the rise; the level taken changed on the fall before the prior one
          next_st.cap = {st.tdo_sync[1], st.cap[31:1]};
          next_st.sh  = {1'b0, st.sh[31:1]};
          next_st.tdi = st.sh[1];
          next_st.cnt = st.cnt - 1'b1;
          next_st.tms = (st.cnt == LEN_W'(2));
          if (st.cnt == LEN_W'(1)) begin
            next_st.tms = 1'b1;
            next_st.ph  = T_EXIT;
          end
        end
        default: begin
          // Exit to update, then back to idle
          next_st.tms       = 1'b0;
          next_st.ph        = T_IDLE;
          next_st.rsp_valid = 1'b1;
          // One bit wider than the length, or 32 itself would wrap to zero
          next_st.rsp       = st.cap >> ((LEN_W+1)'(32) - {1'b0, st.len});
        end
      endcase
    end
  end

  // Idle ties on the link: mode select high, clock low
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      st     <= '0;
      st.tms <= 1'b1;
      st.tdi <= 1'b1;
      st.tck <= 1'b0;
      st.ph  <= T_RESET;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ==== shared/bstap_if.sv ====
// Purpose: Four-wire scan link between tester and device
// Assumes: Tester drives clock, mode select and data in
// Notes:   Data out is a level; no clocking block
`timescale 1ns/1ps
interface bstap_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;

  modport tester (output tck, output tms, output tdi, input tdo);
  modport device (input tck, input tms, input tdi, output tdo);
endinterface

// ==== shared/bstap_pkg.sv ====
// Purpose: Shared constants and types for the boundary-scan access port link
// Assumes: Both ends run on clock_in at 25 MHz
// Notes:   Instruction register is 10 bits wide
package bstap_pkg;

  // ----------------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------------
  localparam int        BSTAP_IR_W       = 10;
  localparam logic [9:0] BSTAP_IR_CAPTURE = 10'h155;
  localparam logic [9:0] BSTAP_IR_BYPASS  = 10'h3ff;
  localparam logic [9:0] BSTAP_IR_SAMPLE  = 10'h005;
  localparam logic [9:0] BSTAP_IR_EXTEST  = 10'h00f;
  localparam logic [9:0] BSTAP_IR_RESET   = 10'h3ff;

  // ----------------------------------------------------------------------
  // Boundary register and timing
  // ----------------------------------------------------------------------
  localparam int         BSTAP_PINS      = 4;
  localparam int         BSTAP_CLK_NS    = 40;
  localparam int         BSTAP_TCK_NS    = 320;
  localparam int         BSTAP_HALF_CYC  = (BSTAP_TCK_NS / BSTAP_CLK_NS) / 2;
  localparam logic [7:0] BSTAP_HALF_CNT  = 8'(BSTAP_HALF_CYC);
  localparam int         BSTAP_FIFO_DEPTH = 8;

  typedef enum logic [3:0] {
    BSTAP_RESET, BSTAP_IDLE, BSTAP_SEL_DR, BSTAP_CAP_DR, BSTAP_SH_DR, BSTAP_EX1_DR,
    BSTAP_PAU_DR, BSTAP_EX2_DR, BSTAP_UPD_DR, BSTAP_SEL_IR, BSTAP_CAP_IR,
    BSTAP_SH_IR, BSTAP_EX1_IR, BSTAP_PAU_IR, BSTAP_EX2_IR, BSTAP_UPD_IR
  } bstap_state_t;

  // Standard sixteen-state step on one mode-select level
  function automatic bstap_state_t bstap_next(input bstap_state_t s, input logic m);
    case (s)
      BSTAP_RESET:  bstap_next = m ? BSTAP_RESET  : BSTAP_IDLE;
      BSTAP_IDLE:   bstap_next = m ? BSTAP_SEL_DR : BSTAP_IDLE;
      BSTAP_SEL_DR: bstap_next = m ? BSTAP_SEL_IR : BSTAP_CAP_DR;
      BSTAP_CAP_DR: bstap_next = m ? BSTAP_EX1_DR : BSTAP_SH_DR;
      BSTAP_SH_DR:  bstap_next = m ? BSTAP_EX1_DR : BSTAP_SH_DR;
      BSTAP_EX1_DR: bstap_next = m ? BSTAP_UPD_DR : BSTAP_PAU_DR;
      BSTAP_PAU_DR: bstap_next = m ? BSTAP_EX2_DR : BSTAP_PAU_DR;
      BSTAP_EX2_DR: bstap_next = m ? BSTAP_UPD_DR : BSTAP_SH_DR;
      BSTAP_UPD_DR: bstap_next = m ? BSTAP_SEL_DR : BSTAP_IDLE;
      BSTAP_SEL_IR: bstap_next = m ? BSTAP_RESET  : BSTAP_CAP_IR;
      BSTAP_CAP_IR: bstap_next = m ? BSTAP_EX1_IR : BSTAP_SH_IR;
      BSTAP_SH_IR:  bstap_next = m ? BSTAP_EX1_IR : BSTAP_SH_IR;
      BSTAP_EX1_IR: bstap_next = m ? BSTAP_UPD_IR : BSTAP_PAU_IR;
      BSTAP_PAU_IR: bstap_next = m ? BSTAP_EX2_IR : BSTAP_PAU_IR;
      BSTAP_EX2_IR: bstap_next = m ? BSTAP_UPD_IR : BSTAP_SH_IR;
      default:      bstap_next = m ? BSTAP_SEL_DR : BSTAP_IDLE;
    endcase
  endfunction

endpackage
